/* File: common/fmt_pkg.sv */
package fmt_pkg;

  // ----------------------------------------------------------------
  // output modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_FULL     = 2'h0;
  localparam logic [1:0] MODE_DDR_CMOS = 2'h1;
  localparam logic [1:0] MODE_DDR_LVDS = 2'h2;

  // ----------------------------------------------------------------
  // sample coding
  // ----------------------------------------------------------------
  localparam int          SW         = 16;
  localparam int          PAIRS      = 8;
  localparam logic signed [16:0] FS_POS_RAW = 17'sh07FFF;
  localparam logic signed [16:0] FS_NEG_RAW = 17'sh18000;
  localparam logic [15:0] FS_POS     = 16'h7FFF;
  localparam logic [15:0] FS_NEG     = 16'h8000;
  localparam logic [15:0] MSB_MASK   = 16'h8000;
  localparam logic [15:0] ODD_MASK   = 16'hAAAA;
  localparam logic [15:0] ALL_ONES   = 16'hFFFF;
  localparam logic [15:0] ALL_ZEROS  = 16'h0000;
  localparam logic [15:0] CHECK_A    = 16'h5555;
  localparam logic [15:0] CHECK_B    = 16'hAAAA;

  // ----------------------------------------------------------------
  // test patterns
  // ----------------------------------------------------------------
  localparam logic [1:0] TP_ONES  = 2'h0;
  localparam logic [1:0] TP_ZEROS = 2'h1;
  localparam logic [1:0] TP_ALT   = 2'h2;
  localparam logic [1:0] TP_CHECK = 2'h3;

  // ----------------------------------------------------------------
  // output frame: eight link cycles per sample, 45 degrees each
  // ----------------------------------------------------------------
  localparam logic [2:0] PH_FIRST  = 3'h0;
  localparam logic [2:0] PH_SECOND = 3'h4;
  localparam logic [2:0] PH_LAST   = 3'h7;

  // ----------------------------------------------------------------
  // driver current in microamps, indexed by the select code
  // ----------------------------------------------------------------
  localparam logic [15:0] DRV_UA [8] = '{16'h0DAC, 16'h06D6, 16'h0834, 16'h09C4,
                                         16'h0BB8, 16'h0FA0, 16'h1194, 16'h0DAC};

endpackage

/* File: verilog/adc_dual_output_formatter.sv */
`timescale 1ns/10ps
module adc_dual_output_formatter
(
  input  wire logic               core_clk,
  input  wire logic               link_clk,
  input  wire logic               reset_n,
  input  wire logic               ce,
  input  wire logic               sample_valid,
  input  wire logic signed [16:0] ch1_raw,
  input  wire logic signed [16:0] ch2_raw,
  input  wire logic               serial_cfg,
  input  wire logic [1:0]         out_mode,
  input  wire logic [1:0]         clk_shift,
  input  wire logic               clk_invert,
  input  wire logic               stab_en,
  input  wire logic               twos_comp_en,
  input  wire logic               rand_en,
  input  wire logic               alt_pol_en,
  input  wire logic               tp_en,
  input  wire logic [1:0]         tp_sel,
  input  wire logic [2:0]         drv_sel,
  input  wire logic               term_en,
  output logic [15:0]             ch1_data,
  output logic [15:0]             ch2_data,
  output logic                    ovr_flag_ch1,
  output logic                    ovr_flag_ch2,
  output logic [7:0]              ch1_pair_bits,
  output logic [7:0]              ch1_pair_bits_n,
  output logic [7:0]              ch2_pair_bits,
  output logic [7:0]              ch2_pair_bits_n,
  output logic                    ovr_flag_shared,
  output logic                    ovr_flag_shared_n,
  output logic                    fwd_clk_p,
  output logic                    fwd_clk_n,
  output logic [15:0]             drv_current_ua,
  output logic                    term_active
);

  // ----------------------------------------------------------------
  // core side: saturation and coding
  // ----------------------------------------------------------------
  logic [15:0] hold1_r;
  logic [15:0] hold2_r;
  logic        hovr1_r;
  logic        hovr2_r;
  logic        req_r;
  logic        tp_alt_r;
  logic [1:0]  mode_r;
  logic [15:0] drv_r;
  logic        term_r;

  wire hi1 = ch1_raw > fmt_pkg::FS_POS_RAW;
  wire lo1 = ch1_raw < fmt_pkg::FS_NEG_RAW;
  wire hi2 = ch2_raw > fmt_pkg::FS_POS_RAW;
  wire lo2 = ch2_raw < fmt_pkg::FS_NEG_RAW;

  // signed saturated code
  wire [15:0] sat1 = hi1 ? fmt_pkg::FS_POS : (lo1 ? fmt_pkg::FS_NEG : ch1_raw[15:0]);
  wire [15:0] sat2 = hi2 ? fmt_pkg::FS_POS : (lo2 ? fmt_pkg::FS_NEG : ch2_raw[15:0]);
  wire        ovr1 = hi1 | lo1;
  wire        ovr2 = hi2 | lo2;

  function automatic logic [15:0] shape(input logic [15:0] s);
    logic [15:0] c;
    c = twos_comp_en ? s : (s ^ fmt_pkg::MSB_MASK);
    if (rand_en)
      c[15:1] = c[15:1] ^ {15{c[0]}};
    if (alt_pol_en)
      c = c ^ fmt_pkg::ODD_MASK;
    shape = c;
  endfunction

  // test pattern word and its over-range bit
  wire [15:0] tp_word =
    (tp_sel == fmt_pkg::TP_ONES)  ? fmt_pkg::ALL_ONES  :
    (tp_sel == fmt_pkg::TP_ZEROS) ? fmt_pkg::ALL_ZEROS :
    (tp_sel == fmt_pkg::TP_ALT)   ? (tp_alt_r ? fmt_pkg::ALL_ZEROS : fmt_pkg::ALL_ONES) :
                                    (tp_alt_r ? fmt_pkg::CHECK_B : fmt_pkg::CHECK_A);
  wire tp_ovr = (tp_sel == fmt_pkg::TP_ONES) |
                ((tp_sel == fmt_pkg::TP_ALT) & ~tp_alt_r) |
                ((tp_sel == fmt_pkg::TP_CHECK) & ~tp_alt_r);

  wire [15:0] word1 = tp_en ? tp_word : shape(sat1);
  wire [15:0] word2 = tp_en ? tp_word : shape(sat2);
  wire        flag1 = tp_en ? tp_ovr : ovr1;
  wire        flag2 = tp_en ? tp_ovr : ovr2;

  // parallel strapping cannot reach DDR CMOS; it falls back to full rate
  wire [1:0] mode_eff = (!serial_cfg && out_mode == fmt_pkg::MODE_DDR_CMOS) ?
                        fmt_pkg::MODE_FULL : out_mode;
  wire [15:0] drv_sel_ua = fmt_pkg::DRV_UA[drv_sel];
  wire [15:0] drv_nxt    = term_en ? {drv_sel_ua[14:0], 1'b0} : drv_sel_ua;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold1_r  <= '0;
      hold2_r  <= '0;
      hovr1_r  <= 1'b0;
      hovr2_r  <= 1'b0;
      req_r    <= 1'b0;
      tp_alt_r <= 1'b0;
    end
    else if (ce && sample_valid)
    begin
      // flag rides in the same holding stage as its data
      hold1_r  <= word1;
      hold2_r  <= word2;
      hovr1_r  <= flag1;
      hovr2_r  <= flag2;
      req_r    <= ~req_r;
      tp_alt_r <= ~tp_alt_r;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_r <= fmt_pkg::MODE_FULL;
      drv_r  <= fmt_pkg::DRV_UA[0];
      term_r <= 1'b0;
    end
    else if (ce)
    begin
      mode_r <= mode_eff;
      drv_r  <= drv_nxt;
      term_r <= term_en;
    end
  end

  assign drv_current_ua = drv_r;
  assign term_active    = term_r;

  // ----------------------------------------------------------------
  // crossing into the link domain
  // ----------------------------------------------------------------
  // quasi-static settings pass two flops; holding words are stable
  // while the request toggle travels, so they are copied directly
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic       req_seen_r;

  wire       eff_shift_ok = stab_en;
  wire [7:0] to_link = {ce, req_r, mode_r, clk_shift, clk_invert, eff_shift_ok};

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= to_link;
      sync2_r <= sync1_r;
    end
  end

  wire       l_ce    = sync2_r[7];
  wire       l_req   = sync2_r[6];
  wire [1:0] l_mode  = sync2_r[5:4];
  wire [1:0] l_shift = sync2_r[0] ? sync2_r[3:2] : 2'h0;
  wire       l_inv   = sync2_r[1];
  wire       new_smp = l_req ^ req_seen_r;

  // ----------------------------------------------------------------
  // link side: frame phase, pending sample
  // ----------------------------------------------------------------
  logic [2:0]  ph_r;
  logic [15:0] pend1_r;
  logic [15:0] pend2_r;
  logic        povr1_r;
  logic        povr2_r;

  wire [2:0] ph_nxt    = (ph_r == fmt_pkg::PH_LAST) ? fmt_pkg::PH_FIRST : ph_r + 3'h1;
  wire       at_first  = ph_nxt == fmt_pkg::PH_FIRST;
  wire       at_second = ph_nxt == fmt_pkg::PH_SECOND;
  wire       ddr       = l_mode != fmt_pkg::MODE_FULL;

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ph_r       <= fmt_pkg::PH_FIRST;
      req_seen_r <= 1'b0;
      pend1_r    <= '0;
      pend2_r    <= '0;
      povr1_r    <= 1'b0;
      povr2_r    <= 1'b0;
    end
    else if (l_ce)
    begin
      ph_r       <= ph_nxt;
      req_seen_r <= l_req;
      if (new_smp)
      begin
        pend1_r <= hold1_r;
        pend2_r <= hold2_r;
        povr1_r <= hovr1_r;
        povr2_r <= hovr2_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // bit pairing for DDR
  // ----------------------------------------------------------------
  logic [7:0] ev1;
  logic [7:0] od1;
  logic [7:0] ev2;
  logic [7:0] od2;

  for (genvar k = 0; k < fmt_pkg::PAIRS; k++)
  begin : g_pair
    assign ev1[k] = pend1_r[2*k];
    assign od1[k] = pend1_r[2*k+1];
    assign ev2[k] = pend2_r[2*k];
    assign od2[k] = pend2_r[2*k+1];
  end

  // ----------------------------------------------------------------
  // forwarded clock: low for the first half frame, shifted by 45 deg steps
  // ----------------------------------------------------------------
  wire [2:0] ph_shift = ph_nxt - {1'b0, l_shift};
  wire       clk_base = ph_shift[2];
  wire       clk_nxt  = clk_base ^ l_inv;

  // ----------------------------------------------------------------
  // second half of a DDR frame
  // ----------------------------------------------------------------
  // odd bits and the second flag are frozen at frame start, so a sample
  // landing mid-frame cannot pair new odd bits with old even bits
  logic [7:0] odd1_r;
  logic [7:0] odd2_r;
  logic       oflag2_r;

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      odd1_r   <= '0;
      odd2_r   <= '0;
      oflag2_r <= 1'b0;
    end
    else if (l_ce && at_first)
    begin
      odd1_r   <= od1;
      odd2_r   <= od2;
      oflag2_r <= povr2_r;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic [15:0] fr1_r;
  logic [15:0] fr2_r;
  logic        fo1_r;
  logic        fo2_r;
  logic [7:0]  dp1_r;
  logic [7:0]  dp2_r;
  logic        so_r;
  logic        ck_r;

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fr1_r <= '0;
      fr2_r <= '0;
      fo1_r <= 1'b0;
      fo2_r <= 1'b0;
      dp1_r <= '0;
      dp2_r <= '0;
      so_r  <= 1'b0;
      ck_r  <= 1'b0;
    end
    else if (l_ce)
    begin
      ck_r <= clk_nxt;
      if (at_first)
      begin
        // full rate changes with the falling edge of the unshifted clock
        fr1_r <= ddr ? '0 : pend1_r;
        fr2_r <= ddr ? '0 : pend2_r;
        fo1_r <= ddr ? 1'b0 : povr1_r;
        fo2_r <= ddr ? 1'b0 : povr2_r;
        dp1_r <= ddr ? ev1 : '0;
        dp2_r <= ddr ? ev2 : '0;
        so_r  <= ddr & povr1_r;
      end
      else if (at_second && ddr)
      begin
        dp1_r <= odd1_r;
        dp2_r <= odd2_r;
        so_r  <= oflag2_r;
      end
    end
  end

  // complements of the differential pairs; one flop each keeps skew equal
  logic [7:0] dn1_r;
  logic [7:0] dn2_r;
  logic       son_r;
  logic       ckn_r;

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dn1_r <= 8'hFF;
      dn2_r <= 8'hFF;
      son_r <= 1'b1;
      ckn_r <= 1'b1;
    end
    else if (l_ce)
    begin
      ckn_r <= ~clk_nxt;
      if (at_first)
      begin
        dn1_r <= ddr ? ~ev1 : 8'hFF;
        dn2_r <= ddr ? ~ev2 : 8'hFF;
        son_r <= ~(ddr & povr1_r);
      end
      else if (at_second && ddr)
      begin
        dn1_r <= ~odd1_r;
        dn2_r <= ~odd2_r;
        son_r <= ~oflag2_r;
      end
    end
  end

  assign ch1_data          = fr1_r;
  assign ch2_data          = fr2_r;
  assign ovr_flag_ch1      = fo1_r;
  assign ovr_flag_ch2      = fo2_r;
  assign ch1_pair_bits     = dp1_r;
  assign ch1_pair_bits_n   = dn1_r;
  assign ch2_pair_bits     = dp2_r;
  assign ch2_pair_bits_n   = dn2_r;
  assign ovr_flag_shared   = so_r;
  assign ovr_flag_shared_n = son_r;
  assign fwd_clk_p         = ck_r;
  assign fwd_clk_n         = ckn_r;

endmodule // adc_dual_output_formatter

/* File: verification/fmt_chk.sv */
`timescale 1ns/10ps
module fmt_chk
(
  input wire logic        core_clk,
  input wire logic        link_clk,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic [1:0]  out_mode,
  input wire logic [1:0]  clk_shift,
  input wire logic        clk_invert,
  input wire logic        stab_en,
  input wire logic [2:0]  drv_sel,
  input wire logic        term_en,
  input wire logic [15:0] ch1_data,
  input wire logic        ovr_flag_ch1,
  input wire logic [7:0]  ch1_pair_bits,
  input wire logic [7:0]  ch1_pair_bits_n,
  input wire logic [7:0]  ch2_pair_bits,
  input wire logic [7:0]  ch2_pair_bits_n,
  input wire logic        ovr_flag_shared,
  input wire logic        ovr_flag_shared_n,
  input wire logic        fwd_clk_p,
  input wire logic        fwd_clk_n,
  input wire logic [15:0] drv_current_ua,
  input wire logic        term_active
);
  // ----------------------------------------------------------------
  // age of the last fall of the shifted, uninverted clock
  // ----------------------------------------------------------------
  wire        true_clk = fwd_clk_p ^ clk_invert;
  wire [1:0]  eff      = stab_en ? clk_shift : 2'h0;
  wire        full     = out_mode == fmt_pkg::MODE_FULL;
  wire        lvds     = out_mode == fmt_pkg::MODE_DDR_LVDS;
  logic [3:0] since_r;
  logic       warm_r;

  // first high pulse after reset may be cut short by the frame phase
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
      warm_r <= 1'b0;
    else if ($fell(fwd_clk_p))
      warm_r <= 1'b1;
  end

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
      since_r <= 4'h0;
    else if ($fell(true_clk))
      since_r <= 4'h1;
    else
      since_r <= since_r + 4'h1;
  end

  sequence frame_start;
    since_r == 4'h8 - {2'h0, eff};
  endsequence
  sequence half_start;
    since_r == 4'h8 - {2'h0, eff} || since_r == 4'h4 - {2'h0, eff};
  endsequence

  // ----------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------
  a_clk_compl: assert property (@(posedge link_clk) disable iff (!reset_n)
    fwd_clk_n == !fwd_clk_p) else $error("clock lines not complementary");
  a_shared_compl: assert property (@(posedge link_clk) disable iff (!reset_n)
    ovr_flag_shared_n == !ovr_flag_shared) else $error("shared flag pair not complementary");
  a_clk_duty: assert property (@(posedge link_clk) disable iff (!reset_n)
    warm_r && $rose(fwd_clk_p) |-> fwd_clk_p [*4] ##1 !fwd_clk_p)
    else $error("clock not 4 high 4 low");
  a_pair_compl: assert property (@(posedge link_clk) disable iff (!reset_n)
    {ch1_pair_bits_n, ch2_pair_bits_n} == ~{ch1_pair_bits, ch2_pair_bits})
    else $error("data pairs not complementary");
  a_full_no_pairs: assert property (@(posedge link_clk) disable iff (!reset_n)
    full |-> ch1_pair_bits == 8'h00 && !ovr_flag_shared) else $error("pair pins busy in full");
  a_ddr_no_full: assert property (@(posedge link_clk) disable iff (!reset_n)
    lvds |-> ch1_data == 16'h0000 && !ovr_flag_ch1) else $error("full-rate pins busy in ddr");
  a_data_at_frame: assert property (@(posedge link_clk) disable iff (!reset_n)
    full && $changed(ch1_data) |-> frame_start) else $error("data moved off clock fall");
  a_ovr_aligned: assert property (@(posedge link_clk) disable iff (!reset_n)
    full && $changed(ovr_flag_ch1) |-> frame_start) else $error("flag not aligned to data");
  a_ddr_halves: assert property (@(posedge link_clk) disable iff (!reset_n)
    lvds && $changed(ch1_pair_bits) |-> half_start) else $error("ddr data off clock edges");

  // ----------------------------------------------------------------
  // core side
  // ----------------------------------------------------------------
  a_term_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    ce |=> term_active == $past(term_en)) else $error("termination status stale");
  a_drv_current: assert property (@(posedge core_clk) disable iff (!reset_n)
    ce |=> drv_current_ua == (fmt_pkg::DRV_UA[$past(drv_sel)] << $past(term_en)))
    else $error("driver current wrong");
endmodule // fmt_chk

bind adc_dual_output_formatter fmt_chk fmt_chk_inst (.core_clk, .link_clk, .reset_n, .ce,
  .out_mode, .clk_shift, .clk_invert, .stab_en, .drv_sel, .term_en, .ch1_data, .ovr_flag_ch1,
  .ch1_pair_bits, .ch1_pair_bits_n, .ch2_pair_bits, .ch2_pair_bits_n,
  .ovr_flag_shared, .ovr_flag_shared_n, .fwd_clk_p, .fwd_clk_n,
  .drv_current_ua, .term_active);

/* File: verification/rx_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// receiver: captures on the forwarded clock, strips line coding
// ----------------------------------------------------------------
module rx_model
(
  input  wire logic        reset_n,
  input  wire logic        clk_p,
  input  wire logic        inv,
  input  wire logic        ddr,
  input  wire logic        dec_rand,
  input  wire logic        dec_alt,
  input  wire logic [15:0] d1,
  input  wire logic [15:0] d2,
  input  wire logic        o1,
  input  wire logic        o2,
  input  wire logic [7:0]  p1,
  input  wire logic [7:0]  p2,
  input  wire logic        os,
  output logic [33:0]      word,
  output logic             got
);
  logic [33:0] last;
  logic [16:0] ev;
  wire         rclk = clk_p ^ inv;

  function automatic logic [15:0] dec(input logic [15:0] v);
    logic [15:0] r;
    r = dec_alt ? v ^ 16'hAAAA : v;
    r = (dec_rand && r[0]) ? r ^ 16'hFFFE : r;
    return r;
  endfunction

  function automatic logic [15:0] zip(input logic [7:0] e, input logic [7:0] o);
    logic [15:0] r;
    for (int k = 0; k < 8; k++)
      r[2*k +: 2] = {o[k], e[k]};
    return r;
  endfunction

  initial got = 1'b0;
  // forget the last word so the first one after reset always counts
  always @(negedge reset_n) last = 'x;
  always @(negedge rclk) ev = {os, p2, p1};

  always @(posedge rclk)
  begin
    word = ddr ? {os, dec(zip(ev[15:8], p2)), ev[16], dec(zip(ev[7:0], p1))}
               : {o2, dec(d2), o1, dec(d1)};
    if (word !== last)
    begin
      last = word;
      got  = ~got;
    end
  end
endmodule // rx_model

/* File: verification/tb.sv */
`timescale 1ns/10ps
module tb;
  logic               core_clk, link_clk, reset_n, ce, sample_valid, serial_cfg;
  logic               clk_invert, stab_en, twos_comp_en, rand_en, alt_pol_en, tp_en;
  logic               term_en, dr, da, ddr, got;
  logic [1:0]         out_mode, clk_shift, tp_sel;
  logic [2:0]         drv_sel;
  logic signed [16:0] ch1_raw, ch2_raw;
  logic [15:0]        ch1_data, ch2_data, drv_current_ua;
  logic [7:0]         ch1_pair_bits, ch1_pair_bits_n, ch2_pair_bits, ch2_pair_bits_n;
  logic               ovr_flag_ch1, ovr_flag_ch2, ovr_flag_shared, ovr_flag_shared_n;
  logic               fwd_clk_p, fwd_clk_n, term_active;
  logic [33:0]        word, last_exp;
  logic [33:0]        exp_q[$];
  int                 mismatches, checked, cycles, seed;
  logic [15:0]        rows [12] = '{16'h0002, 16'h3E02, 16'h15E2, 16'h2102, 16'hA6A2, 16'h6D42,
                                    16'h4000, 16'h9402, 16'h0392, 16'h0396, 16'h039A, 16'hA79E};
  logic [15:0]        tbl [8] = '{16'h0DAC, 16'h06D6, 16'h0834, 16'h09C4,
                                  16'h0BB8, 16'h0FA0, 16'h1194, 16'h0DAC};
  logic signed [16:0] edges [5] = '{17'sh07FFF, 17'sh08000, 17'sh18000, 17'sh17FFF, 17'sh00000};

  adc_dual_output_formatter adc_dual_output_formatter_inst (.core_clk, .link_clk, .reset_n, .ce,
    .sample_valid, .ch1_raw, .ch2_raw, .serial_cfg, .out_mode, .clk_shift, .clk_invert,
    .stab_en, .twos_comp_en, .rand_en, .alt_pol_en, .tp_en, .tp_sel, .drv_sel, .term_en,
    .ch1_data, .ch2_data, .ovr_flag_ch1, .ovr_flag_ch2, .ch1_pair_bits, .ch1_pair_bits_n,
    .ch2_pair_bits, .ch2_pair_bits_n, .ovr_flag_shared, .ovr_flag_shared_n, .fwd_clk_p,
    .fwd_clk_n, .drv_current_ua, .term_active);

  rx_model rx_model_inst (.reset_n, .clk_p(fwd_clk_p), .inv(clk_invert), .ddr, .dec_rand(dr),
    .dec_alt(da), .d1(ch1_data), .d2(ch2_data), .o1(ovr_flag_ch1), .o2(ovr_flag_ch2),
    .p1(ch1_pair_bits), .p2(ch2_pair_bits), .os(ovr_flag_shared), .word, .got);

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // expected code word after saturation and the coding the receiver keeps
  function automatic logic [16:0] enc(input logic signed [16:0] r, input logic tw, rn, al);
    logic signed [16:0] s;
    logic [15:0]        c;
    s = r > 17'sh07FFF ? 17'sh07FFF : (r < 17'sh18000 ? 17'sh18000 : r);
    c = s[15:0] ^ 16'h8000;
    if (tw) c = c ^ 16'h8000;
    if (rn && c[0]) c = c ^ 16'hFFFE;
    if (al) c = c ^ 16'hAAAA;
    return {s != r, c};
  endfunction

  task automatic run_row(input logic [15:0] row);
    logic [16:0]        e1, e2;
    logic signed [16:0] r;
    @(negedge core_clk);
    reset_n = 1'b0;
    {out_mode, clk_shift, clk_invert, stab_en, twos_comp_en, rand_en, alt_pol_en, dr, da,
     tp_en, tp_sel, serial_cfg} = row[15:1];
    ddr = out_mode != 2'h0 && !(out_mode == 2'h1 && !serial_cfg);
    drv_sel = 3'($random(seed));
    term_en = 1'($random(seed));
    repeat (12) @(negedge core_clk);
    chk({18'h0, drv_current_ua}, 34'h0DAC);
    reset_n = 1'b1;
    repeat (20) @(negedge core_clk);
    chk({17'h0, term_active, drv_current_ua}, {17'h0, term_en, tbl[drv_sel] << term_en});
    // idle outputs as the receiver decodes them; equal words are never reported
    last_exp = {1'b0, (da ? 16'hAAAA : 16'h0000), 1'b0, (da ? 16'hAAAA : 16'h0000)};
    for (int i = 0; i < 8; i++)
    begin
      r = (i < 5) ? edges[i] : 17'($random(seed) % 40000);
      ch1_raw = r;
      ch2_raw = -r;
      sample_valid = 1'b1;
      e1 = enc(r, twos_comp_en, rand_en && !dr, alt_pol_en && !da);
      e2 = enc(-r, twos_comp_en, rand_en && !dr, alt_pol_en && !da);
      if (tp_en)
        e1 = (tp_sel == 2'h0 || (tp_sel == 2'h2 && !i[0])) ? 17'h1FFFF :
             (tp_sel == 2'h3 ? (i[0] ? 17'h0AAAA : 17'h15555) : 17'h00000);
      if (tp_en)
        e2 = e1;
      if ({e2, e1} !== last_exp)
        exp_q.push_back({e2, e1});
      last_exp = {e2, e1};
      @(negedge core_clk);
      sample_valid = 1'b0;
      repeat (9) @(negedge core_clk);
    end
    repeat (20) @(negedge core_clk);
    chk(34'(exp_q.size()), 34'h0);
    exp_q.delete();
  endtask

  always @(got)
  begin
    if (exp_q.size() > 0)
      chk(word, exp_q.pop_front());
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial
  begin
    seed = 32'h1BFA;
    reset_n = 1'b0;
    ce = 1'b1;
    sample_valid = 1'b0;
    ch1_raw = 17'sh00000;
    ch2_raw = 17'sh00000;
    {out_mode, clk_shift, clk_invert, stab_en, twos_comp_en, rand_en, alt_pol_en, dr, da,
     tp_en, tp_sel, serial_cfg, ddr, drv_sel, term_en} = '0;
    foreach (rows[k])
      run_row(rows[k]);
    tally_and_finish();
  end
endmodule // tb
